/* brownout_pkg.sv */
// shared constants, stage encoding and helpers for the brownout stage controller
package brownout_pkg;

	// comparator flag positions: each bit is high while the input supply is above that level
	localparam int FLAG_W     = 5;
	localparam int FLAG_4V5   = 0;
	localparam int FLAG_4V65  = 1;
	localparam int FLAG_6V3   = 2;
	localparam int FLAG_6V8   = 3;
	localparam int FLAG_7V5   = 4;

	// filter agreement length in clock cycles
	localparam int FILT_CYCLES = 4;

	// defaults for the number of controlled lines
	localparam int PWM_N   = 10;
	localparam int GPIO_N  = 26;
	localparam int RELAY_N = 4;

	// reset value of the filtered flags: supply just above the boot level, so release from reset holds the fault stage
	localparam logic [FLAG_W-1:0] FLAG_RST = 5'h03;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1,
		ST_WARN   = 4'h2,
		ST_FAULT  = 4'h4,
		ST_LOST   = 4'h8
	} stage_e;

	localparam logic [1:0] CODE_NORMAL = 2'h0;
	localparam logic [1:0] CODE_WARN   = 2'h1;
	localparam logic [1:0] CODE_FAULT  = 2'h2;
	localparam logic [1:0] CODE_LOST   = 2'h3;

	function automatic logic [1:0] stage_code(input stage_e s);
		case (s)
			ST_NORMAL: stage_code = CODE_NORMAL;
			ST_WARN:   stage_code = CODE_WARN;
			ST_FAULT:  stage_code = CODE_FAULT;
			default:   stage_code = CODE_LOST;
		endcase
	endfunction

	function automatic logic is_protect(input stage_e s);
		is_protect = (s == ST_FAULT) || (s == ST_LOST);
	endfunction

endpackage

/* supply_flags_if.sv */
// filtered supply comparator flags passed from the filter to the stage controller
`timescale 1ns/1ps
interface supply_flags_if
	import brownout_pkg::*;
();
	logic [FLAG_W-1:0] flags;

	modport src (output flags);
	modport dst (input  flags);
endinterface

/* supply_flag_filter.sv */
// synchroniser and agreement filter for the supply comparator flags
`timescale 1ns/1ps
module supply_flag_filter
	import brownout_pkg::*;
#(
	parameter int LEN = FILT_CYCLES
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_nrst,
	input  wire logic [FLAG_W-1:0] i_cmp_flags,
	supply_flags_if.src            flt
);
	localparam int CW = $clog2(LEN + 1);
	localparam logic [CW-1:0] LAST = CW'(LEN - 1);

	logic [FLAG_W-1:0] sync1_r;
	logic [FLAG_W-1:0] sync2_r;
	logic [FLAG_W-1:0] out_r;
	logic [FLAG_W-1:0] out_nxt;
	logic [CW-1:0]     cnt_r   [FLAG_W];
	logic [CW-1:0]     cnt_nxt [FLAG_W];

	// a flag moves only after the synchronised level disagrees for LEN cycles in a row
	always_comb begin
		out_nxt = out_r;
		for (int i = 0; i < FLAG_W; i++) begin
			cnt_nxt[i] = '0;
			if (sync2_r[i] != out_r[i]) begin
				if (cnt_r[i] == LAST) begin
					out_nxt[i] = sync2_r[i];
				end else begin
					cnt_nxt[i] = cnt_r[i] + CW'(1);
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_r <= FLAG_RST;
			sync2_r <= FLAG_RST;
			out_r   <= FLAG_RST;
			for (int i = 0; i < FLAG_W; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			sync1_r <= i_cmp_flags;
			sync2_r <= sync1_r;
			out_r   <= out_nxt;
			for (int i = 0; i < FLAG_W; i++) begin
				cnt_r[i] <= cnt_nxt[i];
			end
		end
	end

	assign flt.flags = out_r;
endmodule

/* brownout_stage_controller.sv */
// staged brownout response controller: stage machine and protective output gating
// Behaviour
// - the controller watches the input supply level, whose normal range is 7 V to 16 V, through comparator flags.
// - between 6.3 V and 6.8 V the controller is in a warning stage and takes no protective action.
// - between 4.5 V and 6.3 V it enters the fault stage and applies the protective actions.
// - in the fault stage all user supply rails are switched off.
// - on entering the fault stage each PWM generator finishes its current period and then stops.
// - in the fault stage every general-purpose output releases its drive.
// - in the fault stage all forward and reverse relay outputs are held low.
// - in the fault stage CAN-attached motor controllers are disabled.
// - in the fault stage processing and communication keep running.
// - the fault stage lasts until the supply rises above 7.5 V or falls below 4.5 V.
// - below 4.5 V the controller enters the power-lost stage where everything stops and state is lost.
// - the power-lost stage is left only when the supply rises above 4.65 V, which starts a boot.
// - after boot the controller starts in the fault stage and stays there until the supply exceeds 7.5 V.
`timescale 1ns/1ps
module brownout_stage_controller
	import brownout_pkg::*;
#(
	parameter int NPWM   = PWM_N,
	parameter int NGPIO  = GPIO_N,
	parameter int NRELAY = RELAY_N,
	parameter int FLEN   = FILT_CYCLES
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_nrst,
	input  wire logic [FLAG_W-1:0] i_cmp_flags,
	input  wire logic [NPWM-1:0]   i_pwm_period_end,
	input  wire logic [NGPIO-1:0]  i_gpio_oe,
	input  wire logic [NGPIO-1:0]  i_gpio_out,
	input  wire logic [NRELAY-1:0] i_relay_fwd,
	input  wire logic [NRELAY-1:0] i_relay_rev,
	input  wire logic              i_can_motor_en,
	input  wire logic              i_fault_clr,
	output logic [NPWM-1:0]        o_pwm_en,
	output logic [NGPIO-1:0]       o_gpio_oe,
	output logic [NGPIO-1:0]       o_gpio_out,
	output logic [NRELAY-1:0]      o_relay_fwd,
	output logic [NRELAY-1:0]      o_relay_rev,
	output logic                   o_can_motor_en,
	output logic                   o_user_rail_en,
	output logic                   o_core_run,
	output logic                   o_fault_sticky,
	output logic [1:0]             o_stage
);
	supply_flags_if flt_if ();

	supply_flag_filter #(
		.LEN (FLEN)
	) u_filter (
		.i_sys_clk   (i_sys_clk),
		.i_nrst      (i_nrst),
		.i_cmp_flags (i_cmp_flags),
		.flt         (flt_if.src)
	);

	logic [FLAG_W-1:0] flt;
	logic              above_4v5;
	logic              above_4v65;
	logic              above_6v3;
	logic              above_6v8;
	logic              above_7v5;

	assign flt        = flt_if.flags;
	assign above_4v5  = flt[FLAG_4V5];
	assign above_4v65 = flt[FLAG_4V65];
	assign above_6v3  = flt[FLAG_6V3];
	assign above_6v8  = flt[FLAG_6V8];
	assign above_7v5  = flt[FLAG_7V5];

	stage_e stage_r;
	stage_e stage_nxt;

	// stage machine
	always_comb begin
		stage_nxt = stage_r;
		case (stage_r)
			ST_NORMAL: begin
				if (!above_4v5) begin
					stage_nxt = ST_LOST;
				end else if (!above_6v3) begin
					stage_nxt = ST_FAULT;
				end else if (!above_6v8) begin
					stage_nxt = ST_WARN;
				end
			end
			ST_WARN: begin
				if (!above_4v5) begin
					stage_nxt = ST_LOST;
				end else if (!above_6v3) begin
					stage_nxt = ST_FAULT;
				end else if (above_6v8) begin
					stage_nxt = ST_NORMAL;
				end
			end
			ST_FAULT: begin
				if (!above_4v5) begin
					stage_nxt = ST_LOST;
				end else if (above_7v5) begin
					stage_nxt = ST_NORMAL;
				end
			end
			ST_LOST: begin
				if (above_4v65) begin
					stage_nxt = ST_FAULT;
				end
			end
			default: stage_nxt = ST_FAULT;
		endcase
	end

	// power loss is the reset, so the machine boots into the fault stage
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage_r <= ST_FAULT;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	logic              protect;
	logic              lost;
	logic [NPWM-1:0]   pwm_en_r;
	logic [NPWM-1:0]   pwm_en_nxt;
	logic [NGPIO-1:0]  gpio_oe_r;
	logic [NGPIO-1:0]  gpio_oe_nxt;
	logic [NGPIO-1:0]  gpio_out_r;
	logic [NGPIO-1:0]  gpio_out_nxt;
	logic [NRELAY-1:0] fwd_r;
	logic [NRELAY-1:0] fwd_nxt;
	logic [NRELAY-1:0] rev_r;
	logic [NRELAY-1:0] rev_nxt;
	logic              can_r;
	logic              can_nxt;
	logic              rail_r;
	logic              rail_nxt;
	logic              core_r;
	logic              core_nxt;
	logic              sticky_r;
	logic              sticky_nxt;
	logic [1:0]        code_r;
	logic [1:0]        code_nxt;

	assign protect = is_protect(stage_r);
	assign lost    = (stage_r == ST_LOST);

	// output gating from the current stage
	always_comb begin
		if (lost) begin
			pwm_en_nxt = '0;
		end else if (protect) begin
			pwm_en_nxt = pwm_en_r & ~i_pwm_period_end;
		end else begin
			pwm_en_nxt = '1;
		end
		gpio_oe_nxt  = protect ? '0 : i_gpio_oe;
		gpio_out_nxt = i_gpio_out;
		fwd_nxt      = protect ? '0 : i_relay_fwd;
		rev_nxt      = protect ? '0 : i_relay_rev;
		can_nxt      = protect ? 1'b0 : i_can_motor_en;
		rail_nxt     = !protect;
		core_nxt     = !lost;
		code_nxt     = stage_code(stage_r);
		// every cycle in the fault stage sets the flag and wins over a clear; power loss wipes it
		if (lost) begin
			sticky_nxt = 1'b0;
		end else if (stage_r == ST_FAULT) begin
			sticky_nxt = 1'b1;
		end else if (i_fault_clr) begin
			sticky_nxt = 1'b0;
		end else begin
			sticky_nxt = sticky_r;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pwm_en_r   <= '0;
			gpio_oe_r  <= '0;
			gpio_out_r <= '0;
			fwd_r      <= '0;
			rev_r      <= '0;
			can_r      <= 1'b0;
			rail_r     <= 1'b0;
			core_r     <= 1'b0;
			sticky_r   <= 1'b0;
			code_r     <= CODE_FAULT;
		end else begin
			pwm_en_r   <= pwm_en_nxt;
			gpio_oe_r  <= gpio_oe_nxt;
			gpio_out_r <= gpio_out_nxt;
			fwd_r      <= fwd_nxt;
			rev_r      <= rev_nxt;
			can_r      <= can_nxt;
			rail_r     <= rail_nxt;
			core_r     <= core_nxt;
			sticky_r   <= sticky_nxt;
			code_r     <= code_nxt;
		end
	end

	assign o_pwm_en       = pwm_en_r;
	assign o_gpio_oe      = gpio_oe_r;
	assign o_gpio_out     = gpio_out_r;
	assign o_relay_fwd    = fwd_r;
	assign o_relay_rev    = rev_r;
	assign o_can_motor_en = can_r;
	assign o_user_rail_en = rail_r;
	assign o_core_run     = core_r;
	assign o_fault_sticky = sticky_r;
	assign o_stage        = code_r;

	property p_warn_entry;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_NORMAL) && above_4v5 && above_6v3 && !above_6v8 |=> (stage_r == ST_WARN);
	endproperty
	a_warn_entry: assert property (p_warn_entry) else $error("warning stage not entered");

	property p_warn_exit;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_WARN) && above_4v5 && above_6v3 && above_6v8 |=> (stage_r == ST_NORMAL) ##1 (o_stage == CODE_NORMAL);
	endproperty
	a_warn_exit: assert property (p_warn_exit) else $error("normal stage not restored");

	property p_fault_entry;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_NORMAL) && above_4v5 && !above_6v3 |=> (stage_r == ST_FAULT) ##1 (o_stage == CODE_FAULT);
	endproperty
	a_fault_entry: assert property (p_fault_entry) else $error("fault stage not entered");

	property p_fault_hold;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_FAULT) && above_4v5 && !above_7v5 |=> (stage_r == ST_FAULT);
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault stage left early");

	property p_fault_exit;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_FAULT) && above_4v5 && above_7v5 |=> (stage_r == ST_NORMAL) ##1 o_user_rail_en;
	endproperty
	a_fault_exit: assert property (p_fault_exit) else $error("fault stage not released above top level");

	property p_lost_entry;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r != ST_LOST) && !above_4v5 |=> (stage_r == ST_LOST) ##1 (!o_core_run && o_pwm_en == '0);
	endproperty
	a_lost_entry: assert property (p_lost_entry) else $error("power lost stage not entered");

	property p_lost_exit;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_LOST) |=> (stage_r == ($past(above_4v65) ? ST_FAULT : ST_LOST));
	endproperty
	a_lost_exit: assert property (p_lost_exit) else $error("power lost exit wrong");

	property p_protect_out;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		protect |=> !o_user_rail_en && (o_gpio_oe == '0) && !o_can_motor_en;
	endproperty
	a_protect_out: assert property (p_protect_out) else $error("protective outputs not applied");

	property p_relay_low;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		protect |=> (o_relay_fwd == '0) && (o_relay_rev == '0);
	endproperty
	a_relay_low: assert property (p_relay_low) else $error("relay outputs not low");

	property p_pwm_finish;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_FAULT) && pwm_en_r[0] && !i_pwm_period_end[0] |=> o_pwm_en[0];
	endproperty
	a_pwm_finish: assert property (p_pwm_finish) else $error("pwm stopped before period end");

	property p_core_runs;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(stage_r == ST_FAULT) |=> o_core_run && o_fault_sticky;
	endproperty
	a_core_runs: assert property (p_core_runs) else $error("core stopped or fault not flagged in fault stage");
endmodule

/* supply_monitor_model.sv */
// behavioural model of the analogue supply comparators feeding the controller
`timescale 1ns/1ps
module supply_monitor_model
	import brownout_pkg::*;
#(
	parameter int TH_4V5  = 4500,
	parameter int TH_4V65 = 4650,
	parameter int TH_6V3  = 6300,
	parameter int TH_6V8  = 6800,
	parameter int TH_7V5  = 7500
) (
	input  wire logic [15:0]       i_supply_mv,
	output logic [FLAG_W-1:0]      o_cmp_flags
);
	// each flag is high while the supply is above its level
	always_comb begin
		o_cmp_flags            = 5'h00;
		o_cmp_flags[FLAG_4V5]  = (i_supply_mv > TH_4V5);
		o_cmp_flags[FLAG_4V65] = (i_supply_mv > TH_4V65);
		o_cmp_flags[FLAG_6V3]  = (i_supply_mv > TH_6V3);
		o_cmp_flags[FLAG_6V8]  = (i_supply_mv > TH_6V8);
		o_cmp_flags[FLAG_7V5]  = (i_supply_mv > TH_7V5);
	end
endmodule

/* tb_brownout_stage_controller.sv */
// self-checking testbench for the brownout stage controller
`timescale 1ns/1ps
module tb_brownout_stage_controller;
	import brownout_pkg::*;
	logic                 i_sys_clk;
	logic                 i_nrst;
	logic [15:0]          supply_mv;
	logic [FLAG_W-1:0]    cmp_flags;
	logic [PWM_N-1:0]     pwm_end;
	logic [GPIO_N-1:0]    gpio_oe;
	logic [GPIO_N-1:0]    gpio_out;
	logic [RELAY_N-1:0]   relay_fwd;
	logic [RELAY_N-1:0]   relay_rev;
	logic                 can_en;
	logic                 fault_clr;
	logic [PWM_N-1:0]     o_pwm_en;
	logic [GPIO_N-1:0]    o_gpio_oe;
	logic [GPIO_N-1:0]    o_gpio_out;
	logic [RELAY_N-1:0]   o_relay_fwd;
	logic [RELAY_N-1:0]   o_relay_rev;
	logic                 o_can_motor_en;
	logic                 o_user_rail_en;
	logic                 o_core_run;
	logic                 o_fault_sticky;
	logic [1:0]           o_stage;
	int                   err_count;
	int                   checks_done;

	supply_monitor_model mon_u (.i_supply_mv(supply_mv), .o_cmp_flags(cmp_flags));

	brownout_stage_controller dut_u (
		.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cmp_flags(cmp_flags), .i_pwm_period_end(pwm_end),
		.i_gpio_oe(gpio_oe), .i_gpio_out(gpio_out), .i_relay_fwd(relay_fwd), .i_relay_rev(relay_rev),
		.i_can_motor_en(can_en), .i_fault_clr(fault_clr), .o_pwm_en(o_pwm_en), .o_gpio_oe(o_gpio_oe),
		.o_gpio_out(o_gpio_out), .o_relay_fwd(o_relay_fwd), .o_relay_rev(o_relay_rev),
		.o_can_motor_en(o_can_motor_en), .o_user_rail_en(o_user_rail_en), .o_core_run(o_core_run),
		.o_fault_sticky(o_fault_sticky), .o_stage(o_stage));

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// step the supply and let the filter and stage pipeline settle
	task automatic go(input int mv);
		@(negedge i_sys_clk);
		supply_mv = 16'(mv);
		repeat (12) @(negedge i_sys_clk);
	endtask

	task automatic pulse_cycle(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask

	// protective actions other than the pwm stop applied, user data still passing
	task automatic chk_protect();
		chk(o_stage, CODE_FAULT);
		chk(o_user_rail_en, 1'b0);
		chk(o_gpio_oe, '0);
		chk(o_gpio_out, gpio_out);
		chk({o_relay_fwd, o_relay_rev}, '0);
		chk(o_can_motor_en, 1'b0);
		chk(o_core_run, 1'b1);
		chk(o_fault_sticky, 1'b1);
	endtask

	// requests pass while no protection is applied
	task automatic chk_free(input logic [1:0] code);
		chk(o_stage, code);
		chk(o_user_rail_en, 1'b1);
		chk(o_gpio_oe, gpio_oe);
		chk({o_relay_fwd, o_relay_rev}, {relay_fwd, relay_rev});
		chk(o_can_motor_en, can_en);
		chk(o_pwm_en, {PWM_N{1'b1}});
	endtask

	task automatic give_verdict();
		$display("checks_done %0d err_count %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		err_count   = 0;
		checks_done = 0;
		i_nrst      = 1'b0;
		supply_mv   = 16'(5000);
		pwm_end     = '0;
		gpio_oe     = 26'h2AAAAAA;
		gpio_out    = 26'h1555555;
		relay_fwd   = 4'hA;
		relay_rev   = 4'h5;
		can_en      = 1'b1;
		fault_clr   = 1'b0;
		pulse_cycle(10);
		chk(o_stage, CODE_FAULT);
		chk(o_core_run, 1'b0);
		i_nrst = 1'b1;
		pulse_cycle(2);
		chk(o_stage, CODE_FAULT);
		chk(o_core_run, 1'b1);
		pulse_cycle(10);
		chk_protect();
		go(12000);
		chk_free(CODE_NORMAL);
		go(7000);
		chk(o_stage, CODE_NORMAL);
		can_en = 1'b0;
		pulse_cycle(2);
		chk(o_can_motor_en, 1'b0);
		can_en = 1'b1;
		go(6500);
		chk_free(CODE_WARN);
		go(6900);
		chk(o_stage, CODE_NORMAL);
		fault_clr = 1'b1;
		pulse_cycle(1);
		fault_clr = 1'b0;
		pulse_cycle(2);
		chk(o_fault_sticky, 1'b0);
		// short dip that the filter must swallow
		@(negedge i_sys_clk);
		supply_mv = 16'(5500);
		pulse_cycle(2);
		supply_mv = 16'(12000);
		pulse_cycle(12);
		chk(o_stage, CODE_NORMAL);
		chk(o_fault_sticky, 1'b0);
		go(6500);
		go(5500);
		chk_protect();
		chk(o_pwm_en, {PWM_N{1'b1}});
		pwm_end = 10'h001;
		pulse_cycle(1);
		pwm_end = 10'h000;
		pulse_cycle(2);
		chk(o_pwm_en, 10'h3FE);
		fault_clr = 1'b1;
		pulse_cycle(1);
		fault_clr = 1'b0;
		pulse_cycle(2);
		chk(o_fault_sticky, 1'b1);
		go(7000);
		chk_protect();
		go(8000);
		chk_free(CODE_NORMAL);
		chk(o_fault_sticky, 1'b1);
		fault_clr = 1'b1;
		pulse_cycle(1);
		fault_clr = 1'b0;
		pulse_cycle(2);
		chk(o_fault_sticky, 1'b0);
		go(5500);
		chk_protect();
		go(4000);
		chk(o_stage, CODE_LOST);
		chk(o_core_run, 1'b0);
		chk(o_pwm_en, '0);
		go(4600);
		chk(o_stage, CODE_LOST);
		go(5000);
		chk_protect();
		go(12000);
		chk_free(CODE_NORMAL);
		give_verdict();
	end
endmodule
